// ==== hdl/ssdb_xfer.sv ====
// Synchronous serial master with transmit and receive DMA for 256-byte blocks.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

module ssdb_xfer (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [31:0]       reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic [31:0]            reg_rdata_o,
  input  wire logic              start_switch_in_i,
  output logic                   serial_clk_out_o,
  output logic                   serial_tx_pin_o,
  input  wire logic              serial_rx_pin_i,
  output ssdb_pkg::ssdb_req_t    req_o,
  output ssdb_pkg::ssdb_irq_t    irq_o
);

  // Memories: the transmit and receive block buffers.
  logic [7:0] tx_mem [0:ssdb_pkg::BLOCK_LEN-1];
  logic [7:0] rx_mem [0:ssdb_pkg::BLOCK_LEN-1];

  logic [1:0]  sw_sync_q;
  logic [1:0]  rx_sync_q;
  logic [2:0]  smp_q;
  logic        flt_q;
  logic [2:0]  div8_q;
  logic [1:0]  div4_q;
  logic [9:0]  rate_cnt_q;
  logic [8:0]  rate_div_q;
  logic [7:0]  buf_idx_q;
  logic        tx_done_q;
  logic        rx_done_q;
  logic        te_q;
  logic        re_q;
  logic        tie_q;
  logic        rie_q;
  logic        teie_q;
  logic        tx_pend_q;
  logic        rx_pend_q;
  logic        end_pend_q;
  logic        err_q;
  logic [7:0]  tx_data_reg_q;
  logic        tx_data_full_q;
  logic [7:0]  rx_data_reg_q;
  logic [7:0]  tsr_q;
  logic [7:0]  rsr_q;
  logic [2:0]  bit_cnt_q;
  logic        sck_q;
  logic        txd_q;
  logic [8:0]  tx_cnt_q;
  logic [8:0]  rx_cnt_q;
  logic        tx_irq_q;
  logic        rx_irq_q;
  logic [31:0] rdata_q;
  ssdb_pkg::ssdb_eng_t eng_q;

  // Register strobes and selection.
  wire wr_stat = reg_wr_i && (reg_addr_i == ssdb_pkg::OFS_STATUS);
  wire wr_rate = reg_wr_i && (reg_addr_i == ssdb_pkg::OFS_RATE);
  wire wr_idx = reg_wr_i && (reg_addr_i == ssdb_pkg::OFS_BUF_IDX);
  wire wr_txbuf = reg_wr_i && (reg_addr_i == ssdb_pkg::OFS_TX_BUF);
  wire rd_rxbuf = reg_rd_i && (reg_addr_i == ssdb_pkg::OFS_RX_BUF);

  // Clock-rate enables: /8 for the start filter, /4 for the channel.
  wire tick8 = (div8_q == ssdb_pkg::FILT_LAST);
  wire tick4 = (div4_q == ssdb_pkg::CHAN_LAST);
  wire half_tick = tick4 && (rate_cnt_q == {rate_div_q, 1'b1});

  // Start filter: three equal samples at the /8 rate, then falling-edge detect.
  wire [2:0] smp_next = {smp_q[1:0], sw_sync_q[1]};
  wire       flt_fall = tick8 && flt_q && (smp_next == 3'h0);
  wire       blk_idle = tx_done_q && rx_done_q;
  wire       start_go = flt_fall && blk_idle;

  // Engine events: edges of the serial clock and end of a byte.
  wire shifting = (eng_q == ssdb_pkg::ENG_SHIFT);
  wire sck_fall = shifting && half_tick && sck_q;
  wire sck_rise = shifting && half_tick && !sck_q;
  wire byte_done = sck_rise && (bit_cnt_q == ssdb_pkg::BIT_LAST);
  wire idle_load = (eng_q == ssdb_pkg::ENG_IDLE) && te_q && tx_data_full_q;
  wire next_load = byte_done && tx_data_full_q;
  wire tsr_load = idle_load || next_load;
  wire tx_last = byte_done && !tx_data_full_q;

  // DMA requests are honoured only while the matching enables are on.
  wire tx_dma_go = tx_pend_q && te_q && tie_q && !tx_data_full_q
                   && (tx_cnt_q != ssdb_pkg::BLOCK_CNT);
  wire rx_dma_go = rx_pend_q && re_q && rie_q
                   && (rx_cnt_q != ssdb_pkg::BLOCK_CNT);
  wire tx_fin = tx_dma_go && (tx_cnt_q == ssdb_pkg::BLOCK_LAST);
  wire rx_fin = rx_dma_go && (rx_cnt_q == ssdb_pkg::BLOCK_LAST);
  wire end_fire = end_pend_q;
  wire both_off = (rx_fin && (tx_done_q || end_fire))
                  || (end_fire && rx_done_q);

  // Read data multiplexer.
  wire [31:0] stat_word = {26'h0, shifting, err_q, re_q, te_q, rx_done_q, tx_done_q};
  wire [31:0] cnt_word = {7'h0, rx_cnt_q, 7'h0, tx_cnt_q};
  wire [31:0] rd_mux = (reg_addr_i == ssdb_pkg::OFS_STATUS) ? stat_word :
                       (reg_addr_i == ssdb_pkg::OFS_RATE) ? {23'h0, rate_div_q} :
                       (reg_addr_i == ssdb_pkg::OFS_BUF_IDX) ? {24'h0, buf_idx_q} :
                       (reg_addr_i == ssdb_pkg::OFS_RX_BUF) ? {24'h0, rx_mem[buf_idx_q]} :
                       (reg_addr_i == ssdb_pkg::OFS_COUNT) ? cnt_word : 32'h0;

  // Pin synchronisers; only the second stage is read by logic.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sw_sync_q <= 2'h3;
      rx_sync_q <= 2'h3;
    end else begin
      sw_sync_q <= {sw_sync_q[0], start_switch_in_i};
      rx_sync_q <= {rx_sync_q[0], serial_rx_pin_i};
    end
  end

  // Start filter samples and clock dividers.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      smp_q <= 3'h7;
      flt_q <= 1'b1;
      div8_q <= 3'h0;
      div4_q <= 2'h0;
    end else begin
      div8_q <= div8_q + 3'h1;
      div4_q <= div4_q + 2'h1;
      if (tick8) begin
        smp_q <= smp_next;
        if (smp_next == 3'h0) begin
          flt_q <= 1'b0;
        end else if (smp_next == 3'h7) begin
          flt_q <= 1'b1;
        end
      end
    end
  end

  // Half-bit counter runs only while shifting so every byte starts on a full half period.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i || !shifting || tsr_load) begin
      rate_cnt_q <= 10'h0;
    end else if (tick4) begin
      rate_cnt_q <= half_tick ? 10'h0 : rate_cnt_q + 10'h1;
    end
  end

  // Software registers: rate divider, buffer index, transmit buffer fill, read data.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      rate_div_q <= ssdb_pkg::RATE_DIV_RST;
      buf_idx_q <= 8'h00;
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_rd_i ? rd_mux : 32'h0;
      if (wr_rate) begin
        rate_div_q <= reg_wdata_i[8:0];
      end
      if (wr_idx) begin
        buf_idx_q <= reg_wdata_i[7:0];
      end else if (wr_txbuf || rd_rxbuf) begin
        buf_idx_q <= buf_idx_q + 8'h01;
      end
    end
  end

  // Buffer arrays carry no reset; software fills the transmit side before a start.
  always_ff @(posedge sys_clk_i) begin
    if (wr_txbuf) begin
      tx_mem[buf_idx_q] <= reg_wdata_i[7:0];
    end
    if (rx_dma_go) begin
      rx_mem[rx_cnt_q[7:0]] <= rx_data_reg_q;
    end
  end

  // Sequencing of enables and completion flags, done in hardware in place of handlers.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_done_q <= 1'b1;
      rx_done_q <= 1'b1;
      te_q <= 1'b0;
      re_q <= 1'b0;
      tie_q <= 1'b0;
      rie_q <= 1'b0;
      teie_q <= 1'b0;
      tx_cnt_q <= 9'h0;
      rx_cnt_q <= 9'h0;
      tx_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
    end else begin
      tx_irq_q <= tx_fin;
      rx_irq_q <= rx_fin;
      if (start_go) begin
        tx_done_q <= 1'b0;
        rx_done_q <= 1'b0;
        te_q <= 1'b1;
        re_q <= 1'b1;
        tie_q <= 1'b1;
        rie_q <= 1'b1;
        teie_q <= 1'b1;
        tx_cnt_q <= 9'h0;
        rx_cnt_q <= 9'h0;
      end else begin
        if (tx_dma_go) begin
          tx_cnt_q <= tx_cnt_q + 9'h1;
        end
        if (rx_dma_go) begin
          rx_cnt_q <= rx_cnt_q + 9'h1;
        end
        if (tx_fin) begin
          tie_q <= 1'b0;
          teie_q <= 1'b1;
        end
        if (rx_fin) begin
          rie_q <= 1'b0;
          rx_done_q <= 1'b1;
        end
        if (end_fire) begin
          teie_q <= 1'b0;
          tx_done_q <= 1'b1;
        end
        if (both_off) begin
          te_q <= 1'b0;
          re_q <= 1'b0;
        end
      end
    end
  end

  // Pending request flags: a set in the same cycle as a clear wins.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_pend_q <= 1'b0;
      rx_pend_q <= 1'b0;
      end_pend_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      if (tx_dma_go) begin
        tx_pend_q <= 1'b0;
      end
      if (start_go || (tsr_load && tie_q)) begin
        tx_pend_q <= 1'b1;
      end
      if (rx_dma_go) begin
        rx_pend_q <= 1'b0;
      end
      if (byte_done && re_q && rie_q) begin
        rx_pend_q <= 1'b1;
      end
      end_pend_q <= tx_last && teie_q && !tie_q;
      if (wr_stat && reg_wdata_i[ssdb_pkg::ST_OVERRUN]) begin
        err_q <= 1'b0;
      end
      if (byte_done && re_q && rx_pend_q && !rx_dma_go) begin
        err_q <= 1'b1;
      end
    end
  end

  // Transmit DMA: the next buffer byte goes straight into the transmit data register.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      tx_data_reg_q <= 8'h00;
      tx_data_full_q <= 1'b0;
    end else if (tx_dma_go) begin
      tx_data_reg_q <= tx_mem[tx_cnt_q[7:0]];
      tx_data_full_q <= 1'b1;
    end else if (tsr_load) begin
      tx_data_full_q <= 1'b0;
    end
  end

  // Shift engine: data out on the falling edge, sampled in on the rising edge.
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      eng_q <= ssdb_pkg::ENG_IDLE;
      sck_q <= 1'b1;
      txd_q <= 1'b1;
      tsr_q <= 8'h00;
      rsr_q <= 8'h00;
      rx_data_reg_q <= 8'h00;
      bit_cnt_q <= 3'h0;
    end else begin
      case (eng_q)
        ssdb_pkg::ENG_IDLE: begin
          sck_q <= 1'b1;
          if (idle_load) begin
            tsr_q <= tx_data_reg_q;
            bit_cnt_q <= 3'h0;
            eng_q <= ssdb_pkg::ENG_SHIFT;
          end
        end
        ssdb_pkg::ENG_SHIFT: begin
          if (sck_fall) begin
            sck_q <= 1'b0;
            txd_q <= tsr_q[0];
            tsr_q <= {1'b0, tsr_q[7:1]};
          end else if (sck_rise) begin
            sck_q <= 1'b1;
            rsr_q <= {rx_sync_q[1], rsr_q[7:1]};
            bit_cnt_q <= bit_cnt_q + 3'h1;
            if (byte_done) begin
              rx_data_reg_q <= {rx_sync_q[1], rsr_q[7:1]};
              if (next_load) begin
                tsr_q <= tx_data_reg_q;
              end else begin
                eng_q <= ssdb_pkg::ENG_IDLE;
              end
            end
          end
        end
        default: begin
          eng_q <= ssdb_pkg::ENG_IDLE;
        end
      endcase
    end
  end

  // Outputs.
  assign reg_rdata_o = rdata_q;
  assign serial_clk_out_o = sck_q;
  assign serial_tx_pin_o = txd_q;
  assign req_o = {tx_pend_q, rx_pend_q, end_pend_q, err_q}; // Struct order, MSB first.
  assign irq_o = {tx_irq_q, rx_irq_q};

  // Checks next to the logic.
  a_start_enables: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    start_go |=> te_q && re_q && tx_pend_q && !tx_done_q && !rx_done_q)
    else $error("start did not enable the channel");

  a_start_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (flt_fall && !blk_idle) |=> tx_cnt_q >= $past(tx_cnt_q) && rx_cnt_q >= $past(rx_cnt_q))
    else $error("start accepted while block busy");

  a_filter_rate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $changed(flt_q) |-> $past(tick8))
    else $error("filter changed off its sample tick");

  a_clock_fall: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $fell(sck_q) |-> $past(half_tick) && $past(div4_q) == ssdb_pkg::CHAN_LAST)
    else $error("serial clock fell off its rate tick");

  a_lsb_order: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    sck_fall |=> txd_q == $past(tsr_q[0]) && tsr_q[7] == 1'b0)
    else $error("transmit bit order wrong");

  a_tx_dma_take: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_dma_go |=> !tx_pend_q && tx_data_full_q && tx_cnt_q == $past(tx_cnt_q) + 9'h1)
    else $error("transmit DMA transfer wrong");

  a_rx_dma_take: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (rx_dma_go && !byte_done) |=> !rx_pend_q ##0
      rx_mem[$past(rx_cnt_q[7:0])] == $past(rx_data_reg_q))
    else $error("receive DMA transfer wrong");

  a_tx_complete: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    tx_fin |=> irq_o.tx_dma_done_irq && !tie_q && teie_q ##1 !irq_o.tx_dma_done_irq)
    else $error("transmit DMA completion wrong");

  a_rx_complete: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    rx_fin |=> rx_done_q && !rie_q && irq_o.rx_dma_done_irq)
    else $error("receive DMA completion wrong");

  a_both_disable: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $rose(tx_done_q && rx_done_q) |-> !te_q && !re_q)
    else $error("channel left enabled after both done");

  a_tx_end_seq: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (tx_last && teie_q && !tie_q) |=> end_pend_q ##1 (tx_done_q && !teie_q && !end_pend_q))
    else $error("transmit end sequence wrong");

endmodule

`default_nettype wire

// ==== hdl/ssdb_pkg.sv ====
// Package for the synchronous serial block-transfer channel: constants, types and map.
// Functional notes
// - Start-switch falling edge begins one block
// - Start input filtered at periph_clk/8, no interrupt
// - Master mode, internal clock driven out
// - Rate divider sets 38,400 bps from periph_clk/4
// - Clock out, receive in, transmit out
// - Four requests: tx end, empty, full, error
// - Empty request feeds transmit DMA while enabled
// - Transmit DMA loads next byte, then shifted
// - Each received byte raises full request
// - Transmit DMA: incrementing source, 256 bytes
// - Receive DMA: incrementing destination, 256 bytes
// - Receive DMA start clears full pending flag
// - Transmit DMA start clears empty pending flag
// - Transmit done: empty request off, end on
// - Receive done: full request off, flag set
// - Receive done after transmit done disables both
// - Transmit end sets flag, maybe disables both
// - Each DMA channel raises its done interrupt
// - Eight data bits, least significant first
// - Transmit and receive share one clock
// - Enabling transmitter sets empty request immediately
package ssdb_pkg;

  // Timing.
  localparam int unsigned PERIPH_HZ = 200_000_000;
  localparam int unsigned BIT_RATE_BPS = 38_400;
  localparam int unsigned FILT_DIV = 8;
  localparam int unsigned CHAN_DIV = 4;
  // The divider needs nine bits at this clock; eight would wrap and give the wrong rate.
  localparam logic [8:0] RATE_DIV_RST = 9'(PERIPH_HZ / (8 * 2 * BIT_RATE_BPS) - 1);
  localparam logic [2:0] FILT_LAST = 3'(FILT_DIV - 1);
  localparam logic [1:0] CHAN_LAST = 2'(CHAN_DIV - 1);

  // Block length: 256 single-byte transfers per DMA channel.
  localparam int unsigned BLOCK_LEN = 256;
  localparam logic [8:0] BLOCK_CNT = 9'(BLOCK_LEN);
  localparam logic [8:0] BLOCK_LAST = 9'(BLOCK_LEN - 1);
  localparam logic [2:0] BIT_LAST = 3'h7;

  // Register map (byte addresses).
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_BUF_IDX = 8'h08;
  localparam logic [7:0] OFS_TX_BUF = 8'h0C;
  localparam logic [7:0] OFS_RX_BUF = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // Status field positions.
  localparam int unsigned ST_TX_DONE = 0;
  localparam int unsigned ST_RX_DONE = 1;
  localparam int unsigned ST_TX_EN = 2;
  localparam int unsigned ST_RX_EN = 3;
  localparam int unsigned ST_OVERRUN = 4;
  localparam int unsigned ST_BUSY = 5;
  localparam int unsigned CNT_RX_POS = 16;

  // The four event requests of the channel.
  typedef struct packed {
    logic tx_empty_req;
    logic rx_full_req;
    logic tx_end_req;
    logic rx_error_req;
  } ssdb_req_t;

  // DMA completion events.
  typedef struct packed {
    logic tx_dma_done_irq;
    logic rx_dma_done_irq;
  } ssdb_irq_t;

  // Shift engine states.
  typedef enum logic [1:0] {
    ENG_IDLE  = 2'b01,
    ENG_SHIFT = 2'b10
  } ssdb_eng_t;

endpackage

// ==== tb/ssdb_peer.sv ====
// Behavioural model of the external serial peer clocked by the master.
`timescale 1ns/100ps
`default_nettype none

module ssdb_peer (
  input  wire logic sclk_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  logic [7:0] cap [256];
  logic [7:0] shift_q = 8'h00;
  logic [7:0] pat;
  logic       seen_fall = 1'b0;
  logic [2:0] rbit = 3'h0;
  logic [2:0] tbit = 3'h0;
  logic [8:0] rbyte = 9'h000;
  logic [8:0] tbyte = 9'h000;

  initial rx_o = 1'b1;

  // The peer owns no clock, so each receive bit follows a master fall, LSB first.
  always @(negedge sclk_i) begin
    seen_fall = 1'b1;
    pat = rbyte[7:0] ^ 8'h5A;
    rx_o = pat[rbit];
    rbit = rbit + 3'h1;
    if (rbit == 3'h0) begin
      rbyte = rbyte + 9'h001;
    end
  end

  // Sample on master rises; the X to 1 step at power-up is not a real edge.
  always @(posedge sclk_i) begin
    if (seen_fall) begin
      shift_q = {tx_i, shift_q[7:1]};
      tbit = tbit + 3'h1;
      if (tbit == 3'h0) begin
        cap[tbyte[7:0]] = shift_q;
        tbyte = tbyte + 9'h001;
        if (tbyte == 9'h100) begin
          rx_o = ~rx_o; // Released line must not keep the last bit.
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/ssdb_xfer_tb.sv ====
// Self-checking testbench for the synchronous serial block-transfer channel.
`timescale 1ns/100ps
`default_nettype none

module ssdb_xfer_tb;
  logic                sys_clk_i = 1'b0;
  logic                reset_i = 1'b1;
  logic [7:0]          reg_addr_i = 8'h00;
  logic [31:0]         reg_wdata_i = 32'h0000_0000;
  logic                reg_wr_i = 1'b0;
  logic                reg_rd_i = 1'b0;
  logic [31:0]         reg_rdata_o;
  logic                start_switch_in_i = 1'b1;
  logic                serial_clk_out_o;
  logic                serial_tx_pin_o;
  logic                serial_rx_pin_i;
  ssdb_pkg::ssdb_req_t req_o;
  ssdb_pkg::ssdb_irq_t irq_o;
  int                  num_errors = 0;
  int                  comparisons = 0;
  int                  n_txirq = 0, n_rxirq = 0, n_end = 0, n_full = 0, n_empty = 0;
  int                  n_err = 0, n_rise = 0, half_cnt = 0, half_bad = 0;
  int                  full_run = 0, full_max = 0;
  logic                prev_clk = 1'b1, prev_full = 1'b0, prev_empty = 1'b0;
  logic [31:0]         rd;

  always #2.5 sys_clk_i = ~sys_clk_i;

  ssdb_xfer dut (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .start_switch_in_i(start_switch_in_i),
    .serial_clk_out_o(serial_clk_out_o), .serial_tx_pin_o(serial_tx_pin_o),
    .serial_rx_pin_i(serial_rx_pin_i), .req_o(req_o), .irq_o(irq_o)
  );

  ssdb_peer peer (.sclk_i(serial_clk_out_o), .tx_i(serial_tx_pin_o), .rx_o(serial_rx_pin_i));

  // Event counters; irq and end pulses are one cycle wide and error is sticky, so their high cycles are counted; full and empty count rising edges.
  always @(posedge sys_clk_i) begin
    if (!reset_i) begin
      if (irq_o.tx_dma_done_irq === 1'b1) n_txirq++;
      if (irq_o.rx_dma_done_irq === 1'b1) n_rxirq++;
      if (req_o.tx_end_req === 1'b1) n_end++;
      if (req_o.rx_error_req === 1'b1) n_err++;
      if (req_o.rx_full_req === 1'b1 && prev_full !== 1'b1) n_full++;
      if (req_o.tx_empty_req === 1'b1 && prev_empty !== 1'b1) n_empty++;
      full_run = (req_o.rx_full_req === 1'b1) ? full_run + 1 : 0;
      if (full_run > full_max) full_max = full_run;
      half_cnt++;
      if (serial_clk_out_o !== prev_clk) begin
        if (half_cnt < 100 && half_cnt != 8) half_bad++;
        if (serial_clk_out_o === 1'b1) n_rise++;
        half_cnt = 0;
      end
    end
    prev_clk = serial_clk_out_o;
    prev_full = req_o.rx_full_req;
    prev_empty = req_o.tx_empty_req;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    @(negedge sys_clk_i);
    rd = reg_rdata_o;
  endtask

  task automatic t_reset;
    chk({28'h0, req_o}, 32'h0);
    chk({30'h0, irq_o}, 32'h0);
    chk({30'h0, serial_clk_out_o, serial_tx_pin_o}, 32'h3);
    rd_reg(ssdb_pkg::OFS_STATUS);
    chk(rd, 32'h3);
    rd_reg(ssdb_pkg::OFS_RATE);
    chk(rd, {23'h0, ssdb_pkg::RATE_DIV_RST});
    rd_reg(8'hFC);
    chk(rd, 32'h0);
  endtask

  // Fill the transmit buffer and speed the link up to eight cycles per half bit.
  task automatic t_load;
    wr(ssdb_pkg::OFS_BUF_IDX, 32'h0);
    for (int k = 0; k < 256; k++) wr(ssdb_pkg::OFS_TX_BUF, {24'h0, 8'(k * 7 + 3)});
    wr(ssdb_pkg::OFS_RATE, 32'h0);
    rd_reg(ssdb_pkg::OFS_RATE);
    chk(rd, 32'h0);
  endtask

  // A twelve-cycle dip spans at most two filter samples and must not start a block.
  task automatic t_glitch;
    @(posedge sys_clk_i) start_switch_in_i <= 1'b0;
    repeat (12) @(posedge sys_clk_i);
    start_switch_in_i <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    chk({31'h0, serial_clk_out_o}, 32'h1);
    rd_reg(ssdb_pkg::OFS_STATUS);
    chk(rd, 32'h3);
  endtask

  task automatic t_block;
    int w;
    @(posedge sys_clk_i) start_switch_in_i <= 1'b0;
    w = 0;
    while (serial_clk_out_o !== 1'b0 && w < 200) begin
      @(posedge sys_clk_i);
      w++;
    end
    chk({31'h0, serial_clk_out_o}, 32'h0);
    rd_reg(ssdb_pkg::OFS_STATUS);
    chk(rd, 32'h2C);
    repeat (2000) @(posedge sys_clk_i);
    start_switch_in_i <= 1'b1;
    repeat (100) @(posedge sys_clk_i);
    start_switch_in_i <= 1'b0;
    repeat (100) @(posedge sys_clk_i);
    start_switch_in_i <= 1'b1;
    w = 0;
    while ((n_end < 1 || n_rxirq < 1) && w < 40000) begin
      @(posedge sys_clk_i);
      w++;
    end
    repeat (50) @(posedge sys_clk_i);
    rd_reg(ssdb_pkg::OFS_STATUS);
    chk(rd, 32'h3);
    rd_reg(ssdb_pkg::OFS_COUNT);
    chk(rd, {7'h0, ssdb_pkg::BLOCK_CNT, 7'h0, ssdb_pkg::BLOCK_CNT});
    chk(32'(n_txirq), 32'd1);
    chk(32'(n_rxirq), 32'd1);
    chk(32'(n_end), 32'd1);
    chk(32'(n_empty), 32'd256);
    chk(32'(n_full), 32'd256);
    chk(32'(full_max <= 2), 32'd1);
    chk(32'(n_rise), 32'd2048);
    chk(32'(half_bad), 32'd0);
    chk(32'(n_err), 32'd0);
    chk({31'h0, serial_clk_out_o}, 32'h1);
  endtask

  // Compare what the peer saw and what landed in the receive buffer.
  task automatic t_data;
    for (int k = 0; k < 256; k++) chk({24'h0, peer.cap[k]}, {24'h0, 8'(k * 7 + 3)});
    wr(ssdb_pkg::OFS_BUF_IDX, 32'h0);
    for (int k = 0; k < 256; k++) begin
      rd_reg(ssdb_pkg::OFS_RX_BUF);
      chk(rd, {24'h0, 8'(k) ^ 8'h5A});
    end
  endtask

  task automatic print_verdict;
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    t_reset();
    t_load();
    t_glitch();
    t_block();
    t_data();
    print_verdict();
  end

  // Watchdog: one block at the fast rate needs about 33,000 cycles.
  initial begin
    repeat (90000) @(posedge sys_clk_i);
    num_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
